// ---- hdl/otpp_port.sv ----
// Module: one-time PROM program/verify port, device side
// How it works
// - 16256 bytes, addresses 0 to 3F7F
// - Internal address counter, stepped by clock only
// - Byte over low and high nibble pins
// - Mode active only at programming voltages
// - Decode clear, write, verify, inhibit codes
// - Four step pulses advance one location
// - Verify drives byte of current location
// - No erase; programmed bits stay programmed
`timescale 1ns/1ps
`default_nettype none
module otpp_port
  import otpp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic prog_voltage_ok_in,          // Supply at 6 V and programming pin at 12.5 V
  input wire logic [3:0] operation_select_pins_in,
  input wire logic address_step_clock_in,
  input wire logic address_step_clock_inverse_in,
  input wire logic [3:0] data_low_nibble_pins_in,
  input wire logic [3:0] data_high_nibble_pins_in,
  output logic [3:0] data_low_nibble_pins_out,
  output logic [3:0] data_high_nibble_pins_out,
  output logic data_pins_oe_n_out,            // Low while the device drives the data pins
  output logic [13:0] address_out
);
  // ==========================================================
  // Reset release
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // ==========================================================
  // Pin synchronisers: two flops before any logic
  logic [15:0] pin_s1_r;
  logic [15:0] pin_s2_r;
  logic vok_s1_r;
  logic vok_r;
  logic step_s1_r;
  logic step_r;
  logic step_prev_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
      vok_s1_r <= 1'b0;
      vok_r <= 1'b0;
      step_s1_r <= 1'b0;
      step_r <= 1'b0;
      step_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= {address_step_clock_inverse_in, 3'h0, operation_select_pins_in,
                   data_high_nibble_pins_in, data_low_nibble_pins_in};
      pin_s2_r <= pin_s1_r;
      vok_s1_r <= prog_voltage_ok_in;
      vok_r <= vok_s1_r;
      step_s1_r <= address_step_clock_in;
      step_r <= step_s1_r;
      step_prev_r <= step_r;
    end
  end
  // Inverse clock only matters to the oscillator; accepted, not checked
  logic [3:0] sel;
  otpp_byte_t din;
  logic step_rise;
  assign sel = pin_s2_r[11:8];
  assign din = otpp_byte_t'(pin_s2_r[7:0]);
  assign step_rise = step_r && !step_prev_r;

  // ==========================================================
  // Mode decode
  otpp_op_t op;
  always_comb begin
    op = OTPP_OP_IDLE;
    if (vok_r) begin
      if (sel == OTPP_CODE_CLEAR) begin
        op = OTPP_OP_CLEAR;
      end else if (sel == OTPP_CODE_WRITE) begin
        op = OTPP_OP_WRITE;
      end else if (sel == OTPP_CODE_VERIFY) begin
        op = OTPP_OP_VERIFY;
      end else if ((sel & OTPP_INHIBIT_MASK) == OTPP_CODE_INHIBIT) begin
        op = OTPP_OP_INHIBIT;
      end
    end
  end

  // ==========================================================
  // Address counter: four rising steps per location
  logic [13:0] addr_r;
  logic [1:0] step_cnt_r;
  logic wrap_step;
  // The phase within a four-pulse group survives inhibit and verify; only clear and reset zero it
  assign wrap_step = step_rise && (step_cnt_r == OTPP_STEPS_LAST);
  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      addr_r <= 14'h0000;
      step_cnt_r <= 2'h0;
    end else if (op == OTPP_OP_CLEAR) begin
      addr_r <= 14'h0000;
      step_cnt_r <= 2'h0;
    end else if (step_rise && vok_r) begin
      step_cnt_r <= step_cnt_r + 2'h1;
      if (wrap_step) begin
        // Saturate at the last location rather than wrap
        addr_r <= (addr_r == OTPP_LAST_ADDR) ? addr_r : addr_r + 14'h0001;
      end
    end
  end
  assign address_out = addr_r;

  // ==========================================================
  // Cell array: programming can only clear bits (1 to 0)
  // Cells start erased through the declaration; reset never touches them, since a
  // reset that restored ones would amount to an erase
  logic [7:0] mem_r [0:OTPP_DEPTH-1] = '{default: OTPP_ERASED};
  logic [7:0] rd_r;
  always_ff @(posedge sys_clk_in) begin
    if (op == OTPP_OP_WRITE) begin
      // AND keeps any programmed zero; no path restores a one
      mem_r[addr_r] <= mem_r[addr_r] & din;
    end
    rd_r <= mem_r[addr_r];
  end

  // ==========================================================
  // Data pin drive, registered
  always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      data_low_nibble_pins_out <= 4'h0;
      data_high_nibble_pins_out <= 4'h0;
      data_pins_oe_n_out <= 1'b1;
    end else begin
      data_low_nibble_pins_out <= rd_r[3:0];
      data_high_nibble_pins_out <= rd_r[7:4];
      data_pins_oe_n_out <= !(op == OTPP_OP_VERIFY);
    end
  end

  // ==========================================================
  // Checks
  // Pin-to-output latency is fixed, so the checks below count cycles rather than wait
  property p_oe_only_verify;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      !data_pins_oe_n_out |-> $past(op == OTPP_OP_VERIFY);
  endproperty
  a_oe_only_verify: assert property (p_oe_only_verify) else $error("drive outside verify");
  property p_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      op == OTPP_OP_CLEAR |=> addr_r == 14'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");
  property p_no_mode_low_v;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      !vok_r |-> op == OTPP_OP_IDLE;
  endproperty
  a_no_mode_low_v: assert property (p_no_mode_low_v) else $error("mode without voltage");
  property p_addr_step;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      (op != OTPP_OP_CLEAR && vok_r && wrap_step && addr_r != OTPP_LAST_ADDR)
      |=> addr_r == $past(addr_r) + 14'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address not advanced");
  property p_addr_hold;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      (op != OTPP_OP_CLEAR && !wrap_step) |=> $stable(addr_r);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  property p_addr_range;
    @(posedge sys_clk_in) disable iff (!rst_n_r) addr_r <= OTPP_LAST_ADDR;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address out of range");
  property p_verify_data;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      (op == OTPP_OP_VERIFY)[*3] |=> {data_high_nibble_pins_out, data_low_nibble_pins_out}
        == $past(mem_r[addr_r], 2);
  endproperty
  a_verify_data: assert property (p_verify_data) else $error("verify data wrong");
  property p_no_erase;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      op == OTPP_OP_WRITE |=> (mem_r[$past(addr_r)] & ~$past(mem_r[addr_r])) == 8'h00;
  endproperty
  a_no_erase: assert property (p_no_erase) else $error("bit erased");
  property p_oe_when_verify;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      op == OTPP_OP_VERIFY |=> !data_pins_oe_n_out;
  endproperty
  a_oe_when_verify: assert property (p_oe_when_verify) else $error("verify not driving");
  property p_low_v_frozen;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      !vok_r |=> $stable(addr_r) && $stable(step_cnt_r);
  endproperty
  a_low_v_frozen: assert property (p_low_v_frozen) else $error("stepped at low voltage");
  property p_write_only;
    @(posedge sys_clk_in) disable iff (!rst_n_r)
      op != OTPP_OP_WRITE |=> mem_r[$past(addr_r)] == $past(mem_r[addr_r]);
  endproperty
  a_write_only: assert property (p_write_only) else $error("cell changed outside write");
  c_write: cover property (@(posedge sys_clk_in) op == OTPP_OP_WRITE ##1 op == OTPP_OP_INHIBIT);
  c_verify: cover property (@(posedge sys_clk_in) !data_pins_oe_n_out);
  c_advance: cover property (@(posedge sys_clk_in) wrap_step);
  c_clear: cover property (@(posedge sys_clk_in) op == OTPP_OP_CLEAR);
endmodule : otpp_port
`default_nettype wire

// ---- hdl/otpp_pkg.sv ----
// Package: constants and carrier types for the one-time PROM program/verify port
package otpp_pkg;
  // ==========================================================
  // Memory geometry
  localparam int OTPP_DEPTH = 16256;
  localparam logic [13:0] OTPP_LAST_ADDR = 14'h3F7F;
  localparam int OTPP_AW = 14;
  localparam logic [7:0] OTPP_ERASED = 8'hFF; // Unprogrammed cell value
  // ==========================================================
  // Address stepping: four step-clock pulses per location
  localparam logic [1:0] OTPP_STEPS_LAST = 2'h3;
  // ==========================================================
  // Operation select codes, bit3..bit0 as packed
  localparam logic [3:0] OTPP_CODE_CLEAR = 4'h5;  // bit0=H bit1=L bit2=H bit3=L
  localparam logic [3:0] OTPP_CODE_WRITE = 4'hE;  // L,H,H,H
  localparam logic [3:0] OTPP_CODE_VERIFY = 4'hC; // L,L,H,H
  localparam logic [3:0] OTPP_INHIBIT_MASK = 4'hD; // bit1 ignored
  localparam logic [3:0] OTPP_CODE_INHIBIT = 4'hD; // H,x,H,H

  typedef enum {OTPP_OP_IDLE, OTPP_OP_CLEAR, OTPP_OP_WRITE, OTPP_OP_VERIFY,
                OTPP_OP_INHIBIT} otpp_op_t;

  // Data pins grouped as two nibbles
  typedef struct packed {
    logic [3:0] high_nibble;
    logic [3:0] low_nibble;
  } otpp_byte_t;
endpackage : otpp_pkg

// ---- verification/otpp_prog_model.sv ----
// Programmer model driving the program/verify port from the far side
`timescale 1ns/1ps
`default_nettype none
module otpp_prog_model
  import otpp_pkg::*;
(
  input wire logic clk_in,
  output logic [3:0] mode_out,
  output logic step_out,
  output logic step_n_out,
  output otpp_byte_t data_out
);
  otpp_byte_t wr_r;
  logic drive_r;
  // ==========================================================
  // Pins
  initial begin
    mode_out = OTPP_CODE_INHIBIT;
    step_out = 1'h0;
    wr_r = 8'h00;
    drive_r = 1'h0;
  end
  assign step_n_out = ~step_out;
  // Released bus shows the inverse of the last byte so stale data never matches
  assign data_out = drive_r ? wr_r : ~wr_r;
  // ==========================================================
  // Hold one mode for n cycles; data driven in write mode only
  task automatic op(input logic [3:0] code, input otpp_byte_t d, input int n);
    @(negedge clk_in);
    mode_out = code;
    wr_r = d;
    drive_r = (code == OTPP_CODE_WRITE);
    repeat (n) @(negedge clk_in);
  endtask : op
  // Step pulses, four cycles high and four low
  task automatic steps(input int n);
    repeat (n) begin
      step_out = 1'h1;
      repeat (4) @(negedge clk_in);
      step_out = 1'h0;
      repeat (4) @(negedge clk_in);
    end
  endtask : steps
endmodule : otpp_prog_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the program/verify port
`timescale 1ns/1ps
`default_nettype none
module tb
  import otpp_pkg::*;
;
  logic clk, rst_n, volt, stp, stp_n, oe_n;
  logic [3:0] mode, lo, hi;
  logic [13:0] addr;
  otpp_byte_t din;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // ==========================================================
  // Clock, timeout and instances
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Generous ceiling: the whole run needs under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  otpp_prog_model prog (.clk_in(clk), .mode_out(mode), .step_out(stp),
    .step_n_out(stp_n), .data_out(din));
  otpp_port i_otpp_port (.sys_clk_in(clk), .reset_n_in(rst_n), .prog_voltage_ok_in(volt),
    .operation_select_pins_in(mode), .address_step_clock_in(stp),
    .address_step_clock_inverse_in(stp_n), .data_low_nibble_pins_in(din.low_nibble),
    .data_high_nibble_pins_in(din.high_nibble), .data_low_nibble_pins_out(lo),
    .data_high_nibble_pins_out(hi), .data_pins_oe_n_out(oe_n), .address_out(addr));
  // ==========================================================
  // Shared checks and transfers
  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input otpp_byte_t d);
    // Write pulse scaled down from 1 ms; the cells need no dwell time here
    prog.op(OTPP_CODE_WRITE, d, 20);
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
  endtask : wr
  task automatic rd(input otpp_byte_t e);
    prog.op(OTPP_CODE_VERIFY, 8'h00, 12);
    chk("byte", {6'h00, e}, {6'h00, hi, lo});
    chk("oe_n verify", 14'h0000, {13'h0000, oe_n});
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    chk("oe_n inhibit", 14'h0001, {13'h0000, oe_n});
  endtask : rd
  // Write, inhibit, verify until the byte matches, then the scaled extra write
  task automatic burn(input otpp_byte_t d);
    int tries;
    logic ok;
    tries = 0;
    ok = 1'b0;
    while (!ok && tries < 4) begin
      wr(d);
      tries++;
      prog.op(OTPP_CODE_VERIFY, 8'h00, 12);
      ok = ({hi, lo} === d);
      prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    end
    chk("burn tries", 14'h0001, 14'(tries));
    prog.op(OTPP_CODE_WRITE, d, 20 * tries);
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
  endtask : burn
  // ==========================================================
  // Scenarios
  task automatic t_first();
    chk("reset addr", 14'h0000, addr);
    prog.op(OTPP_CODE_CLEAR, 8'h00, 2);
    volt = 1'h1;
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    wr(8'hA5);
    rd(8'hA5);
    $display("test first done");
  endtask : t_first
  task automatic t_step();
    prog.steps(3);
    chk("addr three", 14'h0000, addr);
    prog.steps(1);
    chk("addr four", 14'h0001, addr);
    rd(8'hFF);
    wr(8'h3C);
    rd(8'h3C);
    wr(8'hC3);
    rd(8'h00);
    $display("test step done");
  endtask : t_step
  task automatic t_clear();
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    chk("addr clear", 14'h0000, addr);
    rd(8'hA5);
    prog.op(4'hF, 8'h00, 10);
    chk("oe_n bit1", 14'h0001, {13'h0000, oe_n});
    $display("test clear done");
  endtask : t_clear
  task automatic t_burn();
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    prog.steps(12);
    chk("addr start", 14'h0003, addr);
    for (int k = 0; k < 3; k++) begin
      burn({4'(k), 4'hA});
      prog.steps(4);
    end
    chk("addr end", 14'h0006, addr);
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    prog.steps(12);
    prog.op(OTPP_CODE_VERIFY, 8'h00, 12);
    for (int k = 0; k < 3; k++) begin
      chk("read back", {6'h00, 4'(k), 4'hA}, {6'h00, hi, lo});
      prog.steps(4);
    end
    chk("oe_n stepping", 14'h0000, {13'h0000, oe_n});
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    prog.op(OTPP_CODE_INHIBIT, 8'h00, 8);
    $display("test burn done");
  endtask : t_burn
  task automatic t_volt();
    prog.steps(8);
    chk("addr two", 14'h0002, addr);
    volt = 1'h0;
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    prog.steps(4);
    chk("addr low volt", 14'h0002, addr);
    prog.op(OTPP_CODE_VERIFY, 8'h00, 12);
    chk("oe_n low volt", 14'h0001, {13'h0000, oe_n});
    prog.op(OTPP_CODE_CLEAR, 8'h00, 2);
    volt = 1'h1;
    prog.op(OTPP_CODE_CLEAR, 8'h00, 10);
    chk("addr final clear", 14'h0000, addr);
    volt = 1'h0;
    $display("test volt done");
  endtask : t_volt
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    rst_n = 1'h0;
    volt = 1'h0;
    repeat (20) @(negedge clk);
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
    t_first();
    t_step();
    t_clear();
    t_burn();
    t_volt();
    stop_test();
  end
endmodule : tb
`default_nettype wire
